// file: hw/dot_pkg.sv
// constants, types and register map of the delayed output off timer
// ****************************************************************
// Summary of operation
// ****************************************************************
package dot_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STEP_NS = 100000000; // one timer step, 0.1 s
  localparam int unsigned STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_CYCLES = 3'h4; // synchroniser fill before sampling
  localparam int unsigned CNT_W = 14; // 9000 steps at most

  // ****************************************************************
  // selector ranges
  // ****************************************************************
  localparam logic [3:0] BASE_POS_MAX = 4'h8;
  localparam logic [3:0] BASE_POS_EXT = 4'h5; // first position with delayed extension
  localparam logic [3:0] FACTOR_POS_MAX = 4'hA;
  localparam logic [3:0] START_POS_MAX = 4'h8;
  localparam logic [3:0] APP_POS_MAX = 4'h8;
  localparam logic [9:0] BASE_VAL_0 = 10'h001;
  localparam logic [9:0] BASE_VAL_1 = 10'h00A;
  localparam logic [9:0] BASE_VAL_2 = 10'h064;
  localparam logic [9:0] BASE_VAL_3 = 10'h3E8;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [7:0] TIMER_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int unsigned EV_START = 0;
  localparam int unsigned EV_DONE = 1;
  localparam int unsigned EV_CANCEL = 2;
  localparam int unsigned EV_CFGERR = 3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] start_pos;
    logic [3:0] app_pos;
    logic [3:0] factor_pos;
    logic [3:0] base_pos;
  } dot_cfg_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ON = 2'b01,
    ST_DELAY = 2'b10
  } dot_state_t;

endpackage

// file: hw/dot_sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module dot_sync3 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  wire logic [W-1:0] agree = ~(s2_r ^ s3_r);

  // a bit moves only when stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s2_r & agree) | (q_r & ~agree);
    end
  end
  assign q = q_r;
endmodule

// file: hw/dot_step_div.sv
// step divider: one-cycle enable every N clocks, restartable
`timescale 1ns/1ns
module dot_step_div #(
  parameter int unsigned N = dot_pkg::STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  output logic step
);
  logic [31:0] cnt_r;
  logic step_r;
  wire logic last = (cnt_r == N[31:0] - 32'h1);

  // clr restarts the count so the first step lands a full period later
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
    begin
      cnt_r <= 32'h0;
      step_r <= 1'b0;
    end
    else
    begin
      cnt_r <= last ? 32'h0 : cnt_r + 32'h1;
      step_r <= last;
    end
  end
  assign step = step_r;
endmodule

// file: hw/dot_timer.sv
// off-delay timer for delayed safety outputs with axi4-lite registers
`timescale 1ns/1ns
module dot_timer #(
  parameter int unsigned STEP_CYCLES = dot_pkg::STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic safety_in,
  input wire logic cancel_input_pair_a,
  input wire logic cancel_input_pair_b,
  input wire logic [3:0] base_sel,
  input wire logic [3:0] factor_sel,
  input wire logic [3:0] app_sel,
  input wire logic [3:0] start_sel,
  output logic delayed_out,
  output logic ext_out,
  output logic cfg_error,
  output logic irq
);
  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [18:0] pins_s;
  dot_sync3 #(.W(19)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({safety_in, cancel_input_pair_a, cancel_input_pair_b,
        start_sel, app_sel, factor_sel, base_sel}),
    .q(pins_s)
  );
  wire logic safety_s = pins_s[18];
  wire dot_pkg::dot_cfg_t sel_s = pins_s[15:0];

  // ****************************************************************
  // power-up selector capture and configuration check
  // ****************************************************************
  dot_pkg::dot_cfg_t cfg_r;
  logic [2:0] settle_r;
  logic cfg_ready_r;
  logic cfg_err_r;
  wire logic capture = !cfg_ready_r && (settle_r == dot_pkg::SETTLE_CYCLES);
  // out-of-range positions are settings the hardware cannot honour
  wire logic sel_bad = (sel_s.base_pos == 4'h0) || (sel_s.base_pos > dot_pkg::BASE_POS_MAX)
    || (sel_s.factor_pos == 4'h0) || (sel_s.factor_pos > dot_pkg::FACTOR_POS_MAX)
    || (sel_s.app_pos == 4'h0) || (sel_s.app_pos > dot_pkg::APP_POS_MAX)
    || (sel_s.start_pos == 4'h0) || (sel_s.start_pos > dot_pkg::START_POS_MAX);
  wire logic sel_moved = cfg_ready_r && (sel_s != cfg_r);
  wire logic err_set = (capture && sel_bad) || sel_moved;

  // error is cleared only by reset, i.e. a power cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_r <= 3'h0;
      cfg_ready_r <= 1'b0;
      cfg_r <= '0;
      cfg_err_r <= 1'b0;
    end
    else
    begin
      if (!cfg_ready_r)
        settle_r <= settle_r + 3'h1;
      if (capture)
      begin
        cfg_r <= sel_s;
        cfg_ready_r <= 1'b1;
      end
      if (err_set)
        cfg_err_r <= 1'b1;
    end
  end

  // ****************************************************************
  // delay arithmetic
  // ****************************************************************
  wire logic [1:0] base_idx = cfg_r.base_pos[1:0] - 2'h1; // 1-4 and 5-8 repeat
  wire logic [9:0] base_val = (base_idx == 2'h0) ? dot_pkg::BASE_VAL_0 :
    (base_idx == 2'h1) ? dot_pkg::BASE_VAL_1 :
    (base_idx == 2'h2) ? dot_pkg::BASE_VAL_2 : dot_pkg::BASE_VAL_3;
  wire logic [3:0] factor_tenths = cfg_r.factor_pos - 4'h1;
  // tenths of a second: 1000 x 9 = 9000 fits the counter
  wire logic [13:0] delay_load = 14'({4'h0, base_val} * {10'h0, factor_tenths});
  wire logic ext_delayed = (cfg_r.base_pos >= dot_pkg::BASE_POS_EXT);
  wire logic cancel_s = cfg_r.app_pos[0] ? pins_s[17] : pins_s[16];

  // ****************************************************************
  // state machine
  // ****************************************************************
  dot_pkg::dot_state_t state_r;
  dot_pkg::dot_state_t state_nxt;
  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;
  logic en_r;
  logic step;
  logic [3:0] ev;
  wire logic go_ok = cfg_ready_r && !cfg_err_r && en_r;

  dot_step_div #(.N(STEP_CYCLES)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(state_r != dot_pkg::ST_DELAY),
    .step(step)
  );

  // every exit of delay goes to off, the safe state; on leaves only for delay or off
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ev = 4'h0;
    ev[dot_pkg::EV_CFGERR] = err_set;
    case (state_r)
      dot_pkg::ST_OFF:
        if (go_ok && safety_s)
          state_nxt = dot_pkg::ST_ON;
      dot_pkg::ST_ON:
        if (!go_ok)
          state_nxt = dot_pkg::ST_OFF;
        else if (!safety_s)
        begin
          if (delay_load == 14'h0)
            state_nxt = dot_pkg::ST_OFF;
          else
          begin
            state_nxt = dot_pkg::ST_DELAY;
            cnt_nxt = delay_load;
            ev[dot_pkg::EV_START] = 1'b1;
          end
        end
      dot_pkg::ST_DELAY:
        if (!go_ok)
          state_nxt = dot_pkg::ST_OFF;
        else if (cancel_s)
        begin
          state_nxt = dot_pkg::ST_OFF;
          ev[dot_pkg::EV_CANCEL] = 1'b1;
        end
        else if (step)
        begin
          cnt_nxt = cnt_r - 14'h1;
          if (cnt_r == 14'h1)
          begin
            state_nxt = dot_pkg::ST_OFF;
            ev[dot_pkg::EV_DONE] = 1'b1;
          end
        end
      default:
        state_nxt = dot_pkg::ST_OFF;
    endcase
  end

  logic del_out_r;
  logic ext_out_r;
  // outputs are registered from the next state so they never glitch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= dot_pkg::ST_OFF;
      cnt_r <= 14'h0;
      del_out_r <= 1'b0;
      ext_out_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      del_out_r <= (state_nxt != dot_pkg::ST_OFF);
      ext_out_r <= (state_nxt == dot_pkg::ST_ON)
        || ((state_nxt == dot_pkg::ST_DELAY) && ext_delayed);
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_got_r, w_got_r;
  logic [3:0] status_r, mask_r;
  logic irq_r;
  wire logic aw_take = s_axi_awvalid && awready_r;
  wire logic w_take = s_axi_wvalid && wready_r;
  wire logic wr_do = aw_got_r && w_got_r && !bvalid_r;
  wire logic ar_take = s_axi_arvalid && arready_r;
  wire logic wr_mask = wr_do && (awaddr_r == dot_pkg::MASK_OFS) && wstrb_r[0];
  wire logic wr_ctrl = wr_do && (awaddr_r == dot_pkg::CTRL_OFS) && wstrb_r[0];
  wire logic wr_hit = (awaddr_r == dot_pkg::MASK_OFS) || (awaddr_r == dot_pkg::CTRL_OFS);
  wire logic rd_status = ar_take && (s_axi_araddr == dot_pkg::STATUS_OFS);
  wire logic rd_hit = (s_axi_araddr == dot_pkg::STATUS_OFS) || (s_axi_araddr == dot_pkg::MASK_OFS)
    || (s_axi_araddr == dot_pkg::CONFIG_OFS) || (s_axi_araddr == dot_pkg::TIMER_OFS)
    || (s_axi_araddr == dot_pkg::CTRL_OFS);
  wire logic [31:0] rd_val =
    (s_axi_araddr == dot_pkg::STATUS_OFS) ? {28'h0, status_r} :
    (s_axi_araddr == dot_pkg::MASK_OFS) ? {28'h0, mask_r} :
    (s_axi_araddr == dot_pkg::CONFIG_OFS) ? {14'h0, cfg_err_r, cfg_ready_r, cfg_r} :
    (s_axi_araddr == dot_pkg::TIMER_OFS) ? {14'h0, state_r, 2'h0, cnt_r} :
    (s_axi_araddr == dot_pkg::CTRL_OFS) ? {31'h0, en_r} : 32'h0;
  // a new event wins over the clear of a status read in the same cycle
  wire logic [3:0] status_nxt = (rd_status ? 4'h0 : status_r) | ev;

  // write side: address and data accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dot_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? dot_pkg::RESP_OKAY : dot_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // read side and software-visible registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dot_pkg::RESP_OKAY;
      status_r <= 4'h0;
      mask_r <= dot_pkg::MASK_RST;
      en_r <= dot_pkg::CTRL_EN_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      if (ar_take)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_hit ? dot_pkg::RESP_OKAY : dot_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
      status_r <= status_nxt;
      if (wr_mask)
        mask_r <= wdata_r[3:0];
      if (wr_ctrl)
        en_r <= wdata_r[0];
      irq_r <= |(status_nxt & (wr_mask ? wdata_r[3:0] : mask_r));
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign delayed_out = del_out_r;
  assign ext_out = ext_out_r;
  assign cfg_error = cfg_err_r;
  assign irq = irq_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_no_early_off;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dot_pkg::ST_DELAY) && go_ok && !cancel_s && !(step && cnt_r == 14'h1)
      |=> del_out_r;
  endproperty
  a_no_early_off: assert property (p_no_early_off) else $error("delayed output dropped early");

  property p_load;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dot_pkg::ST_ON) && go_ok && !safety_s && (delay_load != 14'h0)
      |=> (cnt_r == $past(delay_load)) && (state_r == dot_pkg::ST_DELAY);
  endproperty
  a_load: assert property (p_load) else $error("delay not loaded from selectors");

  property p_zero_factor;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_r.factor_pos == 4'h1) && (state_r == dot_pkg::ST_ON) && !safety_s |=> !del_out_r;
  endproperty
  a_zero_factor: assert property (p_zero_factor) else $error("zero factor still delayed");

  property p_base_map;
    @(posedge aclk) disable iff (!aresetn)
    cfg_ready_r && (cfg_r.base_pos == 4'h7) |-> (base_val == 10'h064);
  endproperty
  a_base_map: assert property (p_base_map) else $error("base position 7 not 100");

  property p_ext_inst;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dot_pkg::ST_DELAY) && !ext_delayed |-> !ext_out_r && del_out_r;
  endproperty
  a_ext_inst: assert property (p_ext_inst) else $error("extension output not instantaneous");

  property p_cancel;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dot_pkg::ST_DELAY) && cancel_s |=> !del_out_r && !ext_out_r;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel did not end delay");

  property p_err_safe;
    @(posedge aclk) disable iff (!aresetn)
    cfg_err_r ##1 cfg_err_r |-> !del_out_r && !ext_out_r;
  endproperty
  a_err_safe: assert property (p_err_safe) else $error("outputs on under config error");

  property p_bad_sel;
    @(posedge aclk) disable iff (!aresetn)
    capture && sel_bad |=> cfg_err_r && cfg_ready_r;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("invalid selector not flagged");

  property p_moved;
    @(posedge aclk) disable iff (!aresetn)
    sel_moved |=> cfg_err_r && (cfg_r == $past(cfg_r));
  endproperty
  a_moved: assert property (p_moved) else $error("selector change not flagged");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dot_pkg::ST_DELAY) && go_ok && !cancel_s && step && (cnt_r > 14'h1)
      |=> cnt_r == $past(cnt_r) - 14'h1;
  endproperty
  a_step: assert property (p_step) else $error("timer step miscounted");

  c_expire: cover property (@(posedge aclk) disable iff (!aresetn) ev[dot_pkg::EV_DONE]);
  c_cancel: cover property (@(posedge aclk) disable iff (!aresetn) ev[dot_pkg::EV_CANCEL]);
  c_cfgerr: cover property (@(posedge aclk) disable iff (!aresetn) sel_moved);
endmodule

// file: test/dot_far_side.sv
// far-side model: safety input devices, cancel source and extension relays
`timescale 1ns/1ns
module dot_far_side (
  input wire logic aclk,
  input wire logic ext_out,
  output logic safety_in,
  output logic cancel_input_pair_a,
  output logic cancel_input_pair_b,
  output logic ext_energised
);
  // contacts start open so nothing energises before capture
  initial
  begin
    safety_in = 1'b0;
    cancel_input_pair_a = 1'b0;
    cancel_input_pair_b = 1'b0;
  end

  // extension relays only follow their drive line, no latching of their own
  assign ext_energised = ext_out;

  // safety devices open or close just after an edge, then hold as a level
  task automatic set_safety(input logic v);
    @(posedge aclk);
    safety_in <= v;
  endtask

  // cancel source raises one pair at a time and holds it as a level
  task automatic set_cancel(input logic a, input logic b);
    @(posedge aclk);
    cancel_input_pair_a <= a;
    cancel_input_pair_b <= b;
  endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the delayed output off timer
`timescale 1ns/1ns
module testbench;
  localparam int unsigned STEP = 10;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, base_sel, factor_sel, app_sel, start_sel;
  logic [1:0] bresp, rresp;
  logic safety_in, cancel_a, cancel_b;
  logic delayed_out, ext_out, cfg_error, irq, ext_energised;
  int mismatches, n_checks;

  dot_timer #(.STEP_CYCLES(STEP)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .safety_in(safety_in),
    .cancel_input_pair_a(cancel_a), .cancel_input_pair_b(cancel_b),
    .base_sel(base_sel), .factor_sel(factor_sel), .app_sel(app_sel),
    .start_sel(start_sel), .delayed_out(delayed_out), .ext_out(ext_out),
    .cfg_error(cfg_error), .irq(irq));

  dot_far_side far_u (.aclk(aclk), .ext_out(ext_out), .safety_in(safety_in),
    .cancel_input_pair_a(cancel_a), .cancel_input_pair_b(cancel_b),
    .ext_energised(ext_energised));

  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  // cycle counts carry sync jitter, so they are judged against a window
  task automatic chk_rng(input string w, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      mismatches++;
      $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask

  task automatic hang(input string w);
    mismatches++;
    $display("mismatch %s expected answer seen timeout", w);
    complete_run();
  endtask

  // ****************************************************************
  // bus and pin helpers
  // ****************************************************************
  // selectors only count at power-up, so each configuration gets a fresh reset
  task automatic power_up(input logic [3:0] b, input logic [3:0] f, input logic [3:0] a);
    @(posedge aclk);
    aresetn <= 1'b0;
    base_sel <= b;
    factor_sel <= f;
    app_sel <= a;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !(bvalid === 1'b1 && bready); i++)
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    if (i == 50) hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !(rvalid === 1'b1 && rready); i++)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    if (i == 50) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic energise();
    int i;
    far_u.set_safety(1'b1);
    for (i = 0; i < 20 && delayed_out !== 1'b1; i++)
      @(posedge aclk);
    chk("energised", 32'h1, 32'(delayed_out));
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic scen_regs();
    logic [31:0] d;
    logic [1:0] r;
    power_up(4'h5, 4'h3, 4'h1);
    axi_rd(dot_pkg::MASK_OFS, d, r);
    chk("mask reset", 32'h0, d);
    axi_rd(dot_pkg::CONFIG_OFS, d, r);
    chk("config", 32'h0001_1135, d);
    axi_wr(dot_pkg::STATUS_OFS, 32'hF, r);
    chk("status write", 32'(dot_pkg::RESP_SLVERR), 32'(r));
    axi_wr(8'h14, 32'h1, r);
    chk("unmapped write", 32'(dot_pkg::RESP_SLVERR), 32'(r));
    axi_rd(8'h14, d, r);
    chk("unmapped read", 32'(dot_pkg::RESP_SLVERR), 32'(r));
    // a write with its low strobe off is answered but must leave the mask alone
    wstrb <= 4'h0;
    axi_wr(dot_pkg::MASK_OFS, 32'hF, r);
    chk("no strobe resp", 32'(dot_pkg::RESP_OKAY), 32'(r));
    wstrb <= 4'hF;
    axi_rd(dot_pkg::MASK_OFS, d, r);
    chk("no strobe mask", 32'h0, d);
    // enable off keeps the outputs in the safe state
    axi_wr(dot_pkg::CTRL_OFS, 32'h0, r);
    axi_rd(dot_pkg::CTRL_OFS, d, r);
    chk("ctrl off", 32'h0, d);
    far_u.set_safety(1'b1);
    repeat (8) @(posedge aclk);
    chk("disabled out", 32'h0, 32'(delayed_out));
    axi_wr(dot_pkg::CTRL_OFS, 32'h1, r);
    energise();
    far_u.set_safety(1'b0);
  endtask

  // measure both falls from the pin edge; n is the delay in tenths
  task automatic run_delay(input logic [3:0] b, input logic [3:0] f, input int n);
    int k, td, te;
    power_up(b, f, 4'h1);
    energise();
    far_u.set_safety(1'b0);
    td = 0;
    te = 0;
    for (k = 1; k < n * STEP + 20; k++)
    begin
      @(posedge aclk);
      #1;
      if (te == 0 && ext_energised === 1'b0) te = k;
      if (td == 0 && delayed_out === 1'b0) td = k;
    end
    chk_rng("delay", n * STEP + 3, n * STEP + 8, td);
    if (b < dot_pkg::BASE_POS_EXT)
      chk_rng("ext instant", 3, 6, te);
    else
      chk("ext delayed", 32'(td), 32'(te));
  endtask

  // every base position once, factor spread over the dial
  task automatic scen_delay();
    int ft [8] = '{9, 5, 2, 1, 7, 4, 2, 1};
    int nt [8] = '{8, 40, 100, 0, 6, 30, 100, 0};
    for (int i = 0; i < 8; i++)
      run_delay(4'(i + 1), 4'(ft[i]), nt[i]);
  endtask

  task automatic scen_cancel();
    logic [31:0] d;
    logic [1:0] r;
    power_up(4'h8, 4'hA, 4'h1);
    axi_wr(dot_pkg::MASK_OFS, 32'h4, r);
    energise();
    far_u.set_safety(1'b0);
    repeat (20) @(posedge aclk);
    axi_rd(dot_pkg::TIMER_OFS, d, r);
    chk("timer state", 32'h2, 32'(d[17:16]));
    chk_rng("remaining", 8990, 9000, int'(d[13:0]));
    chk("irq masked", 32'h0, 32'(irq));
    far_u.set_cancel(1'b0, 1'b1);
    repeat (10) @(posedge aclk);
    chk("other pair", 32'h1, 32'(delayed_out));
    far_u.set_cancel(1'b1, 1'b0);
    repeat (6) @(posedge aclk);
    #1;
    chk("cancelled", 32'h0, 32'(delayed_out));
    chk("ext cancelled", 32'h0, 32'(ext_energised));
    chk("irq cancel", 32'h1, 32'(irq));
    axi_rd(dot_pkg::STATUS_OFS, d, r);
    chk("status", 32'h5, d);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, 32'(irq));
    far_u.set_cancel(1'b0, 1'b0);
  endtask

  task automatic scen_cfg();
    power_up(4'h9, 4'h2, 4'h1);
    far_u.set_safety(1'b1);
    repeat (12) @(posedge aclk);
    chk("bad base", 32'h1, 32'(cfg_error));
    chk("bad base out", 32'h0, 32'(delayed_out));
    far_u.set_safety(1'b0);
    start_sel <= 4'h0;
    power_up(4'h5, 4'h2, 4'h1);
    chk("bad start", 32'h1, 32'(cfg_error));
    start_sel <= 4'h1;
    power_up(4'h5, 4'h2, 4'h2);
    energise();
    @(posedge aclk);
    factor_sel <= 4'h3;
    repeat (8) @(posedge aclk);
    chk("changed sel", 32'h1, 32'(cfg_error));
    chk("changed out", 32'h0, 32'(delayed_out));
    far_u.set_safety(1'b0);
  endtask

  // main sequence
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    base_sel = 4'h1;
    factor_sel = 4'h1;
    app_sel = 4'h1;
    start_sel = 4'h1;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge aclk);
    scen_regs();
    scen_delay();
    scen_cancel();
    scen_cfg();
    complete_run();
  end
endmodule
